/* File: rtl/adc_serial_port_config.sv */
// Overview of operation
// - Outside serial mode the four shared pins drive result bits six to nine.
// - Serial mode, clock select low: generate the data clock and drive it out.
// - Serial mode, clock select high: serial clock pin is an input, data follows it.
// - Frame sync polarity low: frame sync is active high.
// - Frame sync polarity high: frame sync is active low.
// - Clock invert flips the serial clock sense, sourced or received.
// - External clock: dual-purpose pin is the daisy-chain data input.
// - Chain input level reaches the data output eighteen clock periods after read start.
// - Internal clock: dual-purpose pin selects read timing.
// - Read timing high: shift the previous result out during conversion.
// - Read timing low: shift the result out only after conversion completes.
// - Serial output presents the result most significant bit first.
// - Internal clock: frame sync asserts at read start, held while data is valid.
// - External clock: data changes on one edge, valid on the other; inversion swaps.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_regs.svh"

module adc_serial_port_config
	import adc_serial_pkg::*;
#(
	parameter int WIDTH = `RESULT_BITS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] mode_pins,
	input wire conv_evt_t conv,
	input wire logic [3:0] shared_in,
	output logic [3:0] shared_out,
	output logic [3:0] shared_oe,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	output logic serial_result_out,
	output logic frame_sync_out
);

	localparam logic [4:0] LAST_BIT = 5'(WIDTH - 1);

	// Pin synchronisers
	logic [1:0] mode_s1_r, mode_s2_r;
	logic [3:0] shared_s1_r, shared_s2_r;
	logic sclk_s1_r, sclk_s2_r, sclk_s3_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			mode_s1_r <= 2'h0;
			mode_s2_r <= 2'h0;
			shared_s1_r <= 4'h0;
			shared_s2_r <= 4'h0;
		end else begin
			mode_s1_r <= mode_pins;
			mode_s2_r <= mode_s1_r;
			shared_s1_r <= shared_in;
			shared_s2_r <= shared_s1_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sclk_s1_r <= 1'b0;
			sclk_s2_r <= 1'b0;
			sclk_s3_r <= 1'b0;
		end else begin
			sclk_s1_r <= sclk_in;
			sclk_s2_r <= sclk_s1_r;
			sclk_s3_r <= sclk_s2_r;
		end
	end

	// Configuration decode
	serial_cfg_t cfg;
	wire serial_mode = (mode_s2_r == `SERIAL_MODE);
	assign cfg = serial_cfg_t'(shared_s2_r);
	wire ext_clk = serial_mode && cfg.clock_source_select;
	wire int_clk = serial_mode && !cfg.clock_source_select;
	wire chain_in = cfg.read_timing_or_chain_in;
	wire read_during = cfg.read_timing_or_chain_in;

	// External clock edges; update edge follows the inversion pin
	wire sclk_rise = sclk_s2_r && !sclk_s3_r;
	wire sclk_fall = !sclk_s2_r && sclk_s3_r;
	wire ext_update = ext_clk && (cfg.serial_clock_invert ? sclk_fall : sclk_rise);

	// Registers and conversion result
	logic [31:0] ctrl_r;
	logic [WIDTH-1:0] result_r;
	logic [31:0] prdata_r;
	read_state_t state_r, state_nxt;
	logic [7:0] div_cnt_r;
	logic phase_r;
	logic [4:0] bit_cnt_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			result_r <= '0;
		end else if (conv.done) begin
			result_r <= conv.result;
		end
	end

	// Read start selection for the internal and external clocks
	wire int_start_during = int_clk && read_during && conv.start;
	wire int_start_after = int_clk && !read_during && conv.done;
	wire int_start = (state_r == ST_IDLE) && (int_start_during || int_start_after);
	wire ext_start = ext_clk && conv.done;
	wire shifter_load = int_start || ext_start;
	// Reading during conversion ships the previous result, the new one is not ready yet
	wire [WIDTH-1:0] load_word = int_start_during ? result_r : conv.result;

	// Internal serial clock: divider tick, two ticks per clock period
	wire [7:0] div_val = ctrl_r[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
	wire tick = (div_cnt_r == div_val);
	wire int_fall = (state_r == ST_SHIFT) && tick && phase_r;
	wire last_bit = int_fall && (bit_cnt_r == LAST_BIT);

	always_ff @(posedge clk) begin
		if (reset || state_r == ST_IDLE || tick) begin
			div_cnt_r <= 8'h00;
		end else begin
			div_cnt_r <= div_cnt_r + 8'h01;
		end
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (int_start) begin
					state_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (last_bit || !int_clk) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			phase_r <= 1'b0;
			bit_cnt_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			if (state_nxt == ST_IDLE) begin
				phase_r <= 1'b0;
				bit_cnt_r <= 5'h00;
			end else if (state_r == ST_SHIFT && tick) begin
				phase_r <= !phase_r;
				if (phase_r) begin
					bit_cnt_r <= bit_cnt_r + 5'h01;
				end
			end
		end
	end

	// Chained bits enter at the bottom and surface after a full word of shifts
	wire shifter_shift = ext_clk ? ext_update : int_fall;
	wire shifter_in = ext_clk && chain_in;

	result_shifter #(
		.WIDTH(WIDTH)
	) u_shifter (
		.clk(clk),
		.reset(reset),
		.load(shifter_load),
		.load_data(load_word),
		.shift(shifter_shift),
		.shift_in(shifter_in),
		.msb(serial_result_out),
		.lsb()
	);

	// Pin drive
	wire frame_active = int_clk && (state_r == ST_SHIFT);
	assign frame_sync_out = frame_active ^ cfg.frame_sync_polarity;
	assign sclk_out = phase_r ^ cfg.serial_clock_invert;
	assign sclk_oe = int_clk;
	assign shared_out = result_r[9:6];
	assign shared_oe = {4{!serial_mode}};

	// APB slave, zero wait states
	wire hit_ctrl = (paddr == `CTRL_OFFSET);
	wire hit_status = (paddr == `STATUS_OFFSET);
	wire hit_result = (paddr == `RESULT_OFFSET);
	wire hit_any = hit_ctrl || hit_status || hit_result;
	wire apb_write = psel && penable && pwrite && hit_ctrl;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`STATUS_CFG_MSB:`STATUS_CFG_LSB] = shared_s2_r;
		status_word[`STATUS_BUSY_BIT] = (state_r == ST_SHIFT);
		status_word[`STATUS_SERIAL_BIT] = serial_mode;
		status_word[`STATUS_MODE_MSB:`STATUS_MODE_LSB] = mode_s2_r;
		status_word[`STATUS_COUNT_MSB:`STATUS_COUNT_LSB] = bit_cnt_r;
	end

	assign rd_mux = hit_ctrl ? ctrl_r :
		hit_status ? status_word :
		hit_result ? 32'(result_r) : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_r <= `CTRL_RESET;
		end else if (apb_write) begin
			ctrl_r <= {24'h000000, pwdata[`CTRL_DIV_MSB:`CTRL_DIV_LSB]};
		end
	end

	// Read data is captured in the setup phase so it is stable for the whole access
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_r <= rd_mux;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence frame_start_s;
		(state_r == ST_IDLE) && int_start;
	endsequence

	sequence frame_body_s;
		(frame_sync_out == !cfg.frame_sync_polarity) [*1] ##1 (state_r == ST_SHIFT);
	endsequence

	parallel_bits_a: assert property (
		(!serial_mode && conv.done) |=> (shared_oe == 4'hF) && (shared_out == $past(conv.result[9:6])))
		else $error("shared pins do not carry result bits six to nine");

	clock_drive_a: assert property (
		(int_clk && $past(int_clk)) |-> sclk_oe)
		else $error("internal clock selected but serial clock not driven");

	clock_input_a: assert property (
		ext_clk |-> !sclk_oe && (state_r == ST_IDLE || $past(int_clk)))
		else $error("external clock selected but serial clock driven");

	sync_high_a: assert property (
		(frame_active && !cfg.frame_sync_polarity) |-> frame_sync_out)
		else $error("active high frame sync not asserted");

	sync_low_a: assert property (
		(frame_active && cfg.frame_sync_polarity) |-> !frame_sync_out)
		else $error("active low frame sync not asserted");

	clock_invert_a: assert property (
		(int_clk && state_r == ST_IDLE) |-> (sclk_out == cfg.serial_clock_invert))
		else $error("idle serial clock level ignores inversion");

	chain_shift_a: assert property (
		(ext_clk && ext_update && !shifter_load) |=> (u_shifter.lsb == $past(chain_in)))
		else $error("chain input not shifted in on update edge");

	during_conv_a: assert property (
		(state_r == ST_IDLE && int_clk && read_during && conv.start)
		|=> (state_r == ST_SHIFT) && (serial_result_out == $past(result_r[WIDTH-1])))
		else $error("read during conversion did not start with previous result");

	after_conv_a: assert property (
		(state_r == ST_IDLE && int_clk && !read_during && !conv.done) |=> (state_r == ST_IDLE))
		else $error("read after conversion started before completion");

	msb_first_a: assert property (
		shifter_load |=> (serial_result_out == $past(load_word[WIDTH-1])))
		else $error("serial output does not begin with the top bit");

	frame_hold_a: assert property (
		frame_start_s |=> frame_body_s)
		else $error("frame sync not raised at read start");

	ext_edge_a: assert property (
		(ext_clk && !ext_update && !shifter_load) |=> $stable(serial_result_out))
		else $error("serial output changed off the update edge");

	frame_length_a: assert property (
		$rose(state_r == ST_SHIFT) && int_clk |-> (bit_cnt_r == 5'h00))
		else $error("frame started with a stale bit count");

endmodule // adc_serial_port_config

`default_nettype wire

/* File: rtl/adc_serial_regs.svh */
`ifndef ADC_SERIAL_REGS_SVH
`define ADC_SERIAL_REGS_SVH

// APB register byte offsets
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define RESULT_OFFSET 12'h008

// CTRL fields and reset value
`define CTRL_DIV_LSB 0
`define CTRL_DIV_MSB 7
`define CTRL_RESET 32'h0000_0003

// STATUS field positions
`define STATUS_CFG_LSB 0
`define STATUS_CFG_MSB 3
`define STATUS_BUSY_BIT 4
`define STATUS_SERIAL_BIT 5
`define STATUS_MODE_LSB 6
`define STATUS_MODE_MSB 7
`define STATUS_COUNT_LSB 8
`define STATUS_COUNT_MSB 12

// Result word and serial framing
`define RESULT_BITS 18
`define CHAIN_DELAY_PERIODS 18
`define SERIAL_MODE 2'h3

`endif

/* File: rtl/adc_serial_pkg.sv */
`include "adc_serial_regs.svh"

package adc_serial_pkg;

	typedef enum logic {ST_IDLE, ST_SHIFT} read_state_t;

	// Shared pin order: bit 0 is the lowest of the four shared pins
	typedef struct packed {
		logic read_timing_or_chain_in;
		logic serial_clock_invert;
		logic frame_sync_polarity;
		logic clock_source_select;
	} serial_cfg_t;

	typedef struct packed {
		logic start;
		logic done;
		logic [`RESULT_BITS-1:0] result;
	} conv_evt_t;

endpackage

/* File: rtl/result_shifter.sv */
`timescale 1ns/1ps
`default_nettype none

module result_shifter #(
	parameter int WIDTH = 18
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	input wire logic shift,
	input wire logic shift_in,
	output logic msb,
	output logic lsb
);

	logic [WIDTH-1:0] shreg_r;

	// Load wins over shift so a new frame never starts one bit late
	always_ff @(posedge clk) begin
		if (reset) begin
			shreg_r <= '0;
		end else if (load) begin
			shreg_r <= load_data;
		end else if (shift) begin
			shreg_r <= {shreg_r[WIDTH-2:0], shift_in};
		end
	end

	assign msb = shreg_r[WIDTH-1];
	assign lsb = shreg_r[0];

endmodule // result_shifter

`default_nettype wire

/* File: rtl/README_dummy_not_used.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verification/serial_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host that clocks results out of the port when the external clock is chosen
module serial_host_model (
	input wire logic go,
	input wire logic invert,
	input wire logic sdata,
	output logic sclk,
	output logic [19:0] got,
	output logic busy
);
	initial begin
		sclk = 1'b0;
		got = '0;
		busy = 1'b0;
	end

	// Clock stands at its idle level between frames
	always @(invert) begin
		if (!busy) begin
			sclk = invert;
		end
	end

	// Host drives update edge first, samples at the opposite edge
	always @(posedge go) begin
		busy = 1'b1;
		#1.3;
		repeat (20) begin
			#32 sclk = ~invert;
			#32 sclk = invert;
			got = {got[18:0], sdata};
		end
		busy = 1'b0;
	end
endmodule // serial_host_model

`default_nettype wire

/* File: verification/test_adc_serial_port_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_regs.svh"

module test_adc_serial_port_config
	import adc_serial_pkg::*;
;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, go, host_busy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] mode_pins;
	conv_evt_t conv;
	logic [3:0] cfg, shared_in, shared_out, shared_oe;
	logic sclk_in, sclk_out, sclk_oe, serial_result_out, frame_sync_out, host_sclk, er;
	logic [19:0] host_got;
	logic [17:0] res;
	int errors, num_checks;

	// Shared pins and the clock pin resolve between whichever side drives them
	assign shared_in = (shared_oe & shared_out) | (~shared_oe & cfg);
	assign sclk_in = sclk_oe ? sclk_out : host_sclk;

	adc_serial_port_config adc_serial_port_config_i (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mode_pins(mode_pins), .conv(conv),
		.shared_in(shared_in), .shared_out(shared_out), .shared_oe(shared_oe),
		.sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.serial_result_out(serial_result_out), .frame_sync_out(frame_sync_out));

	serial_host_model serial_host_model_i (.go(go), .invert(cfg[2]), .sdata(serial_result_out),
		.sclk(host_sclk), .got(host_got), .busy(host_busy));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so a following call never drives psel twice in one step
		@(posedge clk);
	endtask

	task automatic pulse(input logic s, input logic d, input logic [17:0] r);
		conv <= '{start: s, done: d, result: r};
		@(posedge clk);
		conv <= '{start: 1'b0, done: 1'b0, result: r};
	endtask

	function automatic logic [19:0] chain_expect(input logic [17:0] r, input logic c);
		return {r[16:0], {3{c}}};
	endfunction

	// Collects one internally clocked frame on the uninverted rising edges
	task automatic int_frame(input logic pol, input logic inv, input logic [17:0] e);
		logic prev;
		logic [17:0] g;
		int n;
		n = 0;
		g = '0;
		prev = sclk_out ^ inv;
		for (int t = 0; t < 400 && n < 18; t++) begin
			@(posedge clk);
			#1;
			if (!prev && (sclk_out ^ inv)) begin
				g[17 - n] = serial_result_out;
				chk(32'(frame_sync_out), 32'(!pol));
				n++;
			end
			prev = sclk_out ^ inv;
		end
		chk(32'(n), 32'h12);
		chk(32'(g), 32'(e));
		chk(32'(sclk_oe), 32'h1);
		repeat (8) @(posedge clk);
		chk(32'(frame_sync_out), 32'(pol));
		chk(32'(sclk_out), 32'(inv));
	endtask

	initial begin
		#200000;
		errors++;
		complete_run();
	end

	initial begin
		void'($urandom(32'h78DCC3F1));
		errors = 0;
		num_checks = 0;
		{reset, psel, penable, pwrite, go} = 5'h10;
		paddr = '0;
		pwdata = '0;
		mode_pins = 2'h0;
		conv = '0;
		cfg = 4'h0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b0, `CTRL_OFFSET, 32'h0);
		chk(rd, `CTRL_RESET);
		apb(1'b1, `CTRL_OFFSET, 32'h0000_0101);
		apb(1'b0, `CTRL_OFFSET, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, 12'hFFC, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			mode_pins <= 2'($urandom_range(2));
			res = 18'($urandom);
			repeat (3) @(posedge clk);
			pulse(1'b0, 1'b1, res);
			repeat (3) @(posedge clk);
			chk(32'(shared_out), 32'(res[9:6]));
			chk(32'(shared_oe), 32'hF);
			apb(1'b0, `RESULT_OFFSET, 32'h0);
			chk(rd, 32'(res));
		end
		$display("test parallel done");
		mode_pins <= `SERIAL_MODE;
		for (int k = 0; k < 8; k++) begin
			cfg <= {k[2:0], 1'b0};
			res = 18'($urandom);
			repeat (4) @(posedge clk);
			pulse(!k[2], k[2], res);
			repeat (4) @(posedge clk);
			chk(32'(frame_sync_out), 32'(k[0]));
			pulse(k[2], !k[2], res);
			int_frame(k[0], k[1], res);
		end
		$display("test internal clock done");
		for (int k = 0; k < 4; k++) begin
			cfg <= {k[1:0], 1'($urandom), 1'b1};
			res = 18'($urandom);
			repeat (4) @(posedge clk);
			pulse(1'b0, 1'b1, res);
			repeat (3) @(posedge clk);
			chk(32'(serial_result_out), 32'(res[17]));
			chk(32'(sclk_oe), 32'h0);
			chk(32'(frame_sync_out), 32'(cfg[1]));
			chk(32'(shared_oe), 32'h0);
			apb(1'b0, `STATUS_OFFSET, 32'h0);
			chk(rd, 32'(cfg) | (32'h1 << `STATUS_SERIAL_BIT) | (32'h3 << `STATUS_MODE_LSB));
			go <= 1'b1;
			@(posedge clk);
			for (int t = 0; t < 2000 && host_busy; t++) @(posedge clk);
			chk(32'(host_busy), 32'h0);
			go <= 1'b0;
			repeat (6) @(posedge clk);
			chk(32'(host_got), 32'(chain_expect(res, k[1])));
		end
		$display("test external clock done");
		complete_run();
	end
endmodule // test_adc_serial_port_config

`default_nettype wire
